/* rtl/pswc_map.vh */
// register offsets, field positions, mode and status codes and timing counts
// for the power state and wake controller; included by pswc_top.v and pswc_pme_pin.v
`ifndef PSWC_MAP_VH
`define PSWC_MAP_VH
// byte addresses on the wishbone slave
`define PSWC_ADR_PWR_CTRL   8'h00
`define PSWC_ADR_WAKE_WR    8'h04
`define PSWC_ADR_INTERRUPT_STATUS_REGISTER    8'h08
`define PSWC_ADR_PHY_CTRL   8'h0C
// power control register fields
`define PSWC_PC_READY       0
`define PSWC_PC_PIN_EN      1
`define PSWC_PC_PULSE_SEL   2
`define PSWC_PC_FRAME_EN    9
`define PSWC_PC_ENERGY_EN   14
`define PSWC_PC_STAT_LO     4
`define PSWC_PC_MODE_LO     12
// interrupt status register
`define PSWC_IS_WAKE_INT    17
// phy control register fields
`define PSWC_PH_GEN_PD      0
`define PSWC_PH_ED_PD       1
`define PSWC_PH_ED_FLAG     2
// power modes and wake status codes
`define PSWC_MODE_NORMAL    2'h0
`define PSWC_MODE_LIGHT     2'h1
`define PSWC_MODE_DEEP      2'h2
`define PSWC_STAT_NONE      2'h0
`define PSWC_STAT_ENERGY    2'h1
`define PSWC_STAT_FRAME     2'h2
// timing: clock in MHz, pin pulse in ms, ready delay in us
`define PSWC_CLK_MHZ        100
`define PSWC_PULSE_MS       50
`define PSWC_PULSE_CYC      (`PSWC_PULSE_MS * 1000 * `PSWC_CLK_MHZ)
`define PSWC_READY_US       2000
`define PSWC_READY_CYC      (`PSWC_READY_US * `PSWC_CLK_MHZ)
`endif

/* rtl/pswc_pme_pin.v */
// wake event pin driver: static level or one timed pulse per wake event
// assumes synchronous inputs on the system clock and the synchronised reset
`timescale 1ns/1ps
`include "pswc_map.vh"
module pswc_pme_pin #(
  parameter PULSE_CYC = `PSWC_PULSE_CYC
) (
  input  wire i_clk,     // system clock
  input  wire i_rst_n,   // synchronised reset, active low
  input  wire i_active,  // wake source live and enabled for the pin
  input  wire i_pulse,   // pulse select
  output reg  o_pin      // wake event pin level, active high
);
  reg  [31:0] cnt_r;
  reg         done_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= 32'h0;
      done_r <= 1'b0;
      o_pin  <= 1'b0;
    end else if (!i_active) begin
      cnt_r  <= 32'h0;
      done_r <= 1'b0;
      o_pin  <= 1'b0;
    end else if (!i_pulse) begin
      o_pin  <= 1'b1;
      cnt_r  <= 32'h0;
    end else begin
      // timed pulse; a pulse fires once per event, not again until cleared
      if (done_r) begin
        o_pin <= 1'b0;
      end else if (cnt_r == PULSE_CYC) begin
        o_pin  <= 1'b0;
        done_r <= 1'b1;
      end else begin
        o_pin <= 1'b1;
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
endmodule // pswc_pme_pin

/* rtl/pswc_top.v */
// power state and wake controller: normal, light and deep sleep, wake status,
// wake event pin, wake interrupt status bit and phy power-down control bits.
// assumes a classic wishbone master on I_CLK_SYS; phy energy and frame
// detect inputs are asynchronous and are synchronised here.
// Functional notes
// - one normal state, two sleep states made by gating module clocks
// - registers keep their contents through both sleep states
// - sleep entry clears ready; only power control reads allowed until ready
// - writes ignored after reset or wake until one read happens
// - any write to wake write in sleep returns to normal, mode normal
// - mode 01 written enters light sleep and clears ready
// - light sleep keeps core, phy, receive power logic clocks; gates others
// - light sleep enables frame detect; detection sets wake status 10
// - pin asserted on frame wake only with frame enable and pin enable
// - deep sleep stops core, mac and bus clocks, clears ready
// - deep sleep carrier sets wake status 01; pin with energy and pin enable
// - wake interrupt status set on any wake event regardless of pin enable
// - interrupt bit held while internal wake active; then write one clears
// - pulse select gives a 50 ms pin pulse; else pin driven continuously
// - pin released when wake status, matching enable or pin enable clears
// - wake status readable to find which device drives a shared wake line
// - phy general power-down bit holds phy down; clearing resets the phy
// - energy power-down with no energy powers the phy down
// - energy appearing powers phy up and sets the phy energy flag
// - ready set within 2 ms after a wake write
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pswc_map.vh"
module pswc_top #(
  parameter READY_CYC = `PSWC_READY_CYC,
  parameter PULSE_CYC = `PSWC_PULSE_CYC
) (
  input  wire        I_CLK_SYS,       // system clock 100 MHz
  input  wire        I_RST_N,         // asynchronous reset, active low
  input  wire        I_WB_CYC,        // wishbone cycle
  input  wire        I_WB_STB,        // wishbone strobe
  input  wire        I_WB_WE,         // wishbone write enable
  input  wire [7:0]  I_WB_ADR,        // wishbone byte address
  input  wire [3:0]  I_WB_SEL,        // wishbone byte selects
  input  wire [31:0] I_WB_DAT,        // wishbone write data
  input  wire        I_ENERGY,        // phy energy present, async
  input  wire        I_FRAME_DET,     // wake or magic frame seen, async
  output reg  [31:0] O_WB_DAT,        // wishbone read data
  output reg         O_WB_ACK,        // wishbone acknowledge
  output reg         O_WB_ERR,        // wishbone error, unmapped address
  output reg         O_PME,           // wake event pin, active high
  output reg         O_CLK_EN_CORE,   // internal clock enable
  output reg         O_CLK_EN_RXPM,   // receive power management clock enable
  output reg         O_CLK_EN_MAC,    // mac and host interface clock enable
  output reg         O_PHY_PWR_N,     // phy powered down, active low
  output reg         O_PHY_RST        // phy reset pulse after general power-down
);
  localparam ST_NORMAL = 2'h0;
  localparam ST_LIGHT  = 2'h1;
  localparam ST_DEEP   = 2'h2;
  localparam ST_WAKE   = 2'h3;

  reg         rst_m_r;
  reg         rst_n_r;
  reg  [1:0]  en_m_r;
  reg  [1:0]  in_s_r;
  reg  [1:0]  st_r;
  reg  [1:0]  mode_r;
  reg  [1:0]  wstat_r;
  reg         ready_r;
  reg         rd_seen_r;
  reg         pin_en_r;
  reg         pulse_r;
  reg         frame_en_r;
  reg         energy_en_r;
  reg         wint_r;
  reg         gen_pd_r;
  reg         ed_pd_r;
  reg         ed_flag_r;
  reg         energy_d_r;
  reg  [31:0] rcnt_r;
  wire        pin_lvl;
  wire        energy  = in_s_r[0];
  wire        frame   = in_s_r[1];
  // a request held through its ack cycle is not taken twice
  wire        req     = I_WB_CYC & I_WB_STB & ~O_WB_ACK & ~O_WB_ERR;
  wire        wr      = req & I_WB_WE;
  wire        rd      = req & ~I_WB_WE;
  wire        sleep   = (st_r == ST_LIGHT) | (st_r == ST_DEEP);
  wire        mapped  = map_hit(I_WB_ADR);
  // writes need a prior read; only wake write while unready
  wire        wr_ok   = wr & rd_seen_r & (ready_r | (I_WB_ADR == `PSWC_ADR_WAKE_WR));
  wire        wr_pc   = wr_ok & ready_r & (I_WB_ADR == `PSWC_ADR_PWR_CTRL);
  wire        wr_is   = wr_ok & ready_r & (I_WB_ADR == `PSWC_ADR_INTERRUPT_STATUS_REGISTER);
  wire        wr_ph   = wr_ok & ready_r & (I_WB_ADR == `PSWC_ADR_PHY_CTRL);
  wire        wake_wr = wr_ok & (I_WB_ADR == `PSWC_ADR_WAKE_WR) & sleep;
  wire        det_fr  = (st_r == ST_LIGHT) & frame;
  // level test so carrier already present wakes at once
  wire        det_en  = (st_r == ST_DEEP) & energy;
  // internal wake interrupt source: status bit and its matching enable
  wire        wake_act = (wstat_r[1] & frame_en_r) | (wstat_r[0] & energy_en_r);
  // phy reset on a write that releases general power-down
  wire        phy_rst_go = wr_ph & I_WB_SEL[0] & gen_pd_r & ~I_WB_DAT[`PSWC_PH_GEN_PD];
  reg  [1:0]  wstat_nxt;
  reg  [1:0]  st_nxt;

  function map_hit;
    input [7:0] a;
    begin
      map_hit = (a == `PSWC_ADR_PWR_CTRL) | (a == `PSWC_ADR_WAKE_WR) |
                (a == `PSWC_ADR_INTERRUPT_STATUS_REGISTER) | (a == `PSWC_ADR_PHY_CTRL);
    end
  endfunction

  // byte lane gate: bit b is written only when its lane select is set
  function lane;
    input [3:0] sel;
    input integer b;
    begin
      lane = sel[b / 8];
    end
  endfunction

  // mode field write of a given code, used for both sleep entries
  function mode_req;
    input        w;
    input [3:0]  sel;
    input [31:0] d;
    input [1:0]  code;
    begin
      mode_req = w & sel[`PSWC_PC_MODE_LO / 8] & (d[`PSWC_PC_MODE_LO +: 2] == code);
    end
  endfunction

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // first stage read only by the second
  always @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      en_m_r <= 2'h0;
      in_s_r <= 2'h0;
    end else begin
      en_m_r <= {I_FRAME_DET, I_ENERGY};
      in_s_r <= en_m_r;
    end
  end

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_NORMAL: begin
        if (mode_req(wr_pc, I_WB_SEL, I_WB_DAT, `PSWC_MODE_LIGHT)) begin
          st_nxt = ST_LIGHT;
        end else if (mode_req(wr_pc, I_WB_SEL, I_WB_DAT, `PSWC_MODE_DEEP)) begin
          st_nxt = ST_DEEP;
        end
      end
      ST_LIGHT: begin
        if (wake_wr) begin
          st_nxt = ST_WAKE;
        end
      end
      ST_DEEP: begin
        if (wake_wr) begin
          st_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // bus stays usable here so the host can poll ready
        // ready after the resume delay
        if (rcnt_r == READY_CYC - 1) begin
          st_nxt = ST_NORMAL;
        end
      end
      default: st_nxt = ST_NORMAL;
    endcase
  end

  always @* begin
    wstat_nxt = wstat_r;
    // clear first, then sets, so a detection in the clear cycle survives
    // host clear of the status field
    if (wr_pc & lane(I_WB_SEL, `PSWC_PC_STAT_LO)) begin
      wstat_nxt = wstat_nxt & ~I_WB_DAT[`PSWC_PC_STAT_LO +: 2];
    end
    // frame wake code; set wins over clear
    if (det_fr) begin
      wstat_nxt = wstat_nxt | `PSWC_STAT_FRAME;
    end
    if (det_en) begin
      wstat_nxt = wstat_nxt | `PSWC_STAT_ENERGY;
    end
  end

  always @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r        <= ST_NORMAL;
      mode_r      <= `PSWC_MODE_NORMAL;
      wstat_r     <= `PSWC_STAT_NONE;
      ready_r     <= 1'b1;
      rd_seen_r   <= 1'b0;
      pin_en_r    <= 1'b0;
      pulse_r     <= 1'b0;
      frame_en_r  <= 1'b0;
      energy_en_r <= 1'b0;
      wint_r      <= 1'b0;
      gen_pd_r    <= 1'b0;
      ed_pd_r     <= 1'b0;
      ed_flag_r   <= 1'b0;
      energy_d_r  <= 1'b0;
      rcnt_r      <= 32'h0;
    end else begin
      st_r       <= st_nxt;
      // status stays 00 until a detection
      wstat_r    <= wstat_nxt;
      energy_d_r <= energy;
      if (st_r == ST_WAKE) begin
        rcnt_r <= rcnt_r + 32'h1;
      end else begin
        rcnt_r <= 32'h0;
      end
      // ready follows the state the next edge enters, so it tracks st_r
      // ready cleared on sleep entry
      if (st_nxt == ST_LIGHT || st_nxt == ST_DEEP) begin
        ready_r <= 1'b0;
      end else if (st_nxt == ST_NORMAL) begin
        ready_r <= 1'b1;
      end
      // limitation: a read refused while unready still counts as the first read
      // a fresh read is needed after each wake
      if (wake_wr) begin
        rd_seen_r <= 1'b0;
      end else if (rd) begin
        rd_seen_r <= 1'b1;
      end
      if (wake_wr) begin
        mode_r <= `PSWC_MODE_NORMAL;
      end else if (st_nxt == ST_LIGHT && st_r == ST_NORMAL) begin
        mode_r <= `PSWC_MODE_LIGHT;
      end else if (st_nxt == ST_DEEP && st_r == ST_NORMAL) begin
        mode_r <= `PSWC_MODE_DEEP;
      end
      // fields change only by host writes
      if (wr_pc & I_WB_SEL[0]) begin
        pin_en_r <= I_WB_DAT[`PSWC_PC_PIN_EN];
        pulse_r  <= I_WB_DAT[`PSWC_PC_PULSE_SEL];
      end
      if (wr_pc & I_WB_SEL[1]) begin
        frame_en_r  <= I_WB_DAT[`PSWC_PC_FRAME_EN];
        energy_en_r <= I_WB_DAT[`PSWC_PC_ENERGY_EN];
      end
      // set while wake active; write one clears only once inactive
      if (wake_act | det_fr | det_en) begin
        wint_r <= 1'b1;
      end else if (wr_is & lane(I_WB_SEL, `PSWC_IS_WAKE_INT) &
                   I_WB_DAT[`PSWC_IS_WAKE_INT]) begin
        wint_r <= 1'b0;
      end
      if (wr_ph & I_WB_SEL[0]) begin
        gen_pd_r <= I_WB_DAT[`PSWC_PH_GEN_PD];
        ed_pd_r  <= I_WB_DAT[`PSWC_PH_ED_PD];
      end
      // phy energy flag, set wins over write-one clear
      if (ed_pd_r & energy & ~energy_d_r) begin
        ed_flag_r <= 1'b1;
      end else if (wr_ph & I_WB_SEL[0] & I_WB_DAT[`PSWC_PH_ED_FLAG]) begin
        ed_flag_r <= 1'b0;
      end
    end
  end

  pswc_pme_pin #(
    .PULSE_CYC (PULSE_CYC)
  ) u_pin (
    .i_clk    (I_CLK_SYS),
    .i_rst_n  (rst_n_r),
    .i_active (wake_act & pin_en_r),
    .i_pulse  (pulse_r),
    .o_pin    (pin_lvl)
  );

  always @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      O_WB_DAT      <= 32'h0;
      O_WB_ACK      <= 1'b0;
      O_WB_ERR      <= 1'b0;
      O_PME         <= 1'b0;
      O_CLK_EN_CORE <= 1'b1;
      O_CLK_EN_RXPM <= 1'b1;
      O_CLK_EN_MAC  <= 1'b1;
      O_PHY_PWR_N   <= 1'b1;
      O_PHY_RST     <= 1'b0;
    end else begin
      O_PME <= pin_lvl;
      // enables are fed from st_nxt so the gate closes on the same edge
      // that the state register moves
      // clock gating per state
      O_CLK_EN_CORE <= (st_nxt != ST_DEEP);
      O_CLK_EN_RXPM <= (st_nxt != ST_DEEP);
      O_CLK_EN_MAC  <= (st_nxt == ST_NORMAL) | (st_nxt == ST_WAKE);
      // phy power-down; energy brings it back unless general power-down is set
      O_PHY_PWR_N   <= ~(gen_pd_r | (ed_pd_r & ~energy));
      // reset pulse as general power-down is released
      O_PHY_RST     <= phy_rst_go;
      O_WB_ACK      <= req & mapped;
      O_WB_ERR      <= req & ~mapped;
      // data returns to zero outside ack so a stale read cannot be mistaken
      O_WB_DAT      <= 32'h0;
      // only power control readable while unready
      if (rd & (ready_r | (I_WB_ADR == `PSWC_ADR_PWR_CTRL))) begin
        case (I_WB_ADR)
          `PSWC_ADR_PWR_CTRL: begin
            O_WB_DAT[`PSWC_PC_READY]        <= ready_r;
            O_WB_DAT[`PSWC_PC_PIN_EN]       <= pin_en_r;
            O_WB_DAT[`PSWC_PC_PULSE_SEL]    <= pulse_r;
            O_WB_DAT[`PSWC_PC_STAT_LO +: 2] <= wstat_r;
            O_WB_DAT[`PSWC_PC_FRAME_EN]     <= frame_en_r;
            O_WB_DAT[`PSWC_PC_MODE_LO +: 2] <= mode_r;
            O_WB_DAT[`PSWC_PC_ENERGY_EN]    <= energy_en_r;
          end
          `PSWC_ADR_INTERRUPT_STATUS_REGISTER: begin
            O_WB_DAT[`PSWC_IS_WAKE_INT] <= wint_r;
          end
          `PSWC_ADR_PHY_CTRL: begin
            O_WB_DAT[`PSWC_PH_GEN_PD]  <= gen_pd_r;
            O_WB_DAT[`PSWC_PH_ED_PD]   <= ed_pd_r;
            O_WB_DAT[`PSWC_PH_ED_FLAG] <= ed_flag_r;
          end
          default: O_WB_DAT <= 32'h0;
        endcase
      end
    end
  end
endmodule // pswc_top

/* dv/pswc_props.sv */
// port assertions for the power state and wake controller
// assumes one clock domain; I_RST_N low disables every check
`timescale 1ns/1ps
module pswc_props (
  input wire        I_CLK_SYS,     // clock
  input wire        I_RST_N,       // reset, active low
  input wire        I_WB_CYC,      // cycle
  input wire        I_WB_STB,      // strobe
  input wire        I_WB_WE,       // write
  input wire [7:0]  I_WB_ADR,      // address
  input wire [31:0] O_WB_DAT,      // read data
  input wire        O_WB_ACK,      // ack
  input wire        O_WB_ERR,      // error
  input wire        O_CLK_EN_CORE, // core clock on
  input wire        O_CLK_EN_RXPM, // rx power logic clock on
  input wire        O_CLK_EN_MAC,  // mac clock on
  input wire        O_PHY_RST      // phy reset pulse
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  wire mapped = (I_WB_ADR[1:0] == 2'h0) && (I_WB_ADR <= 8'h0C);
  sequence s_take;
    I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR;
  endsequence
  chk_bus_answer: assert property (s_take |=> O_WB_ACK ^ O_WB_ERR)
    else $error("request not answered by exactly one of ack or err");
  chk_err_unmapped: assert property (s_take |=> O_WB_ERR == !$past(mapped))
    else $error("err does not match the address map");
  chk_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");
  chk_data_idle: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
    else $error("read data driven outside ack");
  chk_mac_core: assert property (O_CLK_EN_MAC |-> O_CLK_EN_CORE)
    else $error("mac clock on while core clock off");
  chk_rxpm_core: assert property (O_CLK_EN_RXPM == O_CLK_EN_CORE)
    else $error("rx power clock differs from core clock");
  chk_phy_rst: assert property (O_PHY_RST |=> !O_PHY_RST)
    else $error("phy reset pulse too long");
  // sleep is only reached through an accepted write, so a read was already seen
  chk_wake_write: assert property (s_take ##0 (I_WB_WE && I_WB_ADR == 8'h04
    && !O_CLK_EN_MAC) |=> ##[0:2] O_CLK_EN_MAC)
    else $error("wake write did not leave sleep");
endmodule // pswc_props
bind pswc_top pswc_props u_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_WB_ERR(O_WB_ERR),
  .O_CLK_EN_CORE(O_CLK_EN_CORE), .O_CLK_EN_RXPM(O_CLK_EN_RXPM),
  .O_CLK_EN_MAC(O_CLK_EN_MAC), .O_PHY_RST(O_PHY_RST));

/* dv/pswc_line_model.sv */
// phy and line side model: carrier energy and wake frame detect
// assumes the bench commands carrier and frames on the system clock
`timescale 1ns/1ps
module pswc_line_model (
  input  wire i_clk,       // system clock
  input  wire i_carrier,   // bench: carrier on the line
  input  wire i_frame_go,  // bench: one wake frame arrives
  output reg  o_energy,    // energy present
  output reg  o_frame_det  // frame detect level
);
  reg [2:0] hold_r = 3'h0;
  initial o_energy = 1'b0;
  initial o_frame_det = 1'b0;
  always @(posedge i_clk) o_energy <= i_carrier;
  // frame level held
  // held several cycles so the two-flop sync cannot miss it
  always @(posedge i_clk) begin
    if (i_frame_go)
      hold_r <= 3'h6;
    else if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
    o_frame_det <= (hold_r != 3'h0);
  end
endmodule // pswc_line_model

/* dv/tb.sv */
// testbench: register access, sleep entry, wake and wake pin checks
// assumes shortened ready and pulse counts on the design instance
`timescale 1ns/1ps
module tb;
  localparam int RDY = 20;
  localparam int PLS = 16;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic        carrier = 0, frame_go = 0, rerr, seen;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0, rdat, rv;
  wire         energy, frame, ack, err, pme, ce_core, ce_rxpm, ce_mac, pwr_n, prst;
  int          err_total = 0, n_checks = 0, tick = 0, n;
  always #5 clk = ~clk;
  always @(posedge clk) tick <= tick + 1;
  pswc_line_model LINE (.i_clk(clk), .i_carrier(carrier), .i_frame_go(frame_go),
    .o_energy(energy), .o_frame_det(frame));
  pswc_top #(.READY_CYC(RDY), .PULSE_CYC(PLS)) DUT (.I_CLK_SYS(clk), .I_RST_N(rst_n),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .I_ENERGY(energy), .I_FRAME_DET(frame), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .O_WB_ERR(err), .O_PME(pme), .O_CLK_EN_CORE(ce_core),
    .O_CLK_EN_RXPM(ce_rxpm), .O_CLK_EN_MAC(ce_mac), .O_PHY_PWR_N(pwr_n),
    .O_PHY_RST(prst));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
    rv = rdat;
    rerr = err;
    if (k >= 20) err_total++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_pme(input logic lvl);
    n = 0;
    while (pme !== lvl && n < 60) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic wake_wait(input logic [31:0] exp);
    int t0;
    bus(1, 8'h04, 4'hF, 32'h5A5A_0F0F);
    t0 = tick;
    bus(0, 8'h00, 4'hF, 0);
    chk(rv[0], 0);
    while (rv[0] !== 1'b1 && tick - t0 < RDY + 40) bus(0, 8'h00, 4'hF, 0);
    chk(tick - t0 <= RDY + 8, 1);
    chk(rv, exp);
    chk({ce_core, ce_rxpm, ce_mac}, 3'b111);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1, 8'h00, 4'h1, 32'h2);
    bus(0, 8'h00, 4'hF, 0);
    chk(rv, 32'h1);
    bus(1, 8'h00, 4'h1, 32'h2);
    bus(0, 8'h00, 4'hF, 0);
    chk(rv, 32'h3);
    bus(0, 8'h10, 4'hF, 0);
    chk(rerr, 1);
    $display("test reset and map done");
    bus(1, 8'h00, 4'h3, 32'h1202);
    bus(0, 8'h00, 4'hF, 0);
    chk(rv, 32'h1202);
    chk({ce_core, ce_rxpm, ce_mac}, 3'b110);
    bus(0, 8'h08, 4'hF, 0);
    chk(rv, 0);
    frame_go <= 1'b1;
    @(posedge clk);
    frame_go <= 1'b0;
    wait_pme(1);
    chk(pme, 1);
    bus(0, 8'h00, 4'hF, 0);
    chk(rv, 32'h1222);
    wake_wait(32'h0223);
    bus(0, 8'h08, 4'hF, 0);
    chk(rv, 32'h20000);
    bus(1, 8'h08, 4'h4, 32'h20000);
    bus(0, 8'h08, 4'hF, 0);
    chk(rv, 32'h20000);
    bus(1, 8'h00, 4'h1, 32'h22);
    wait_pme(0);
    chk(pme, 0);
    bus(0, 8'h00, 4'hF, 0);
    chk(rv, 32'h0203);
    bus(1, 8'h08, 4'h4, 32'h20000);
    bus(0, 8'h08, 4'hF, 0);
    chk(rv, 0);
    $display("test light sleep done");
    carrier <= 1'b1;
    bus(1, 8'h0C, 4'h1, 32'h2);
    bus(1, 8'h00, 4'h3, 32'h6006);
    wait_pme(1);
    chk({ce_core, ce_rxpm, ce_mac}, 3'b000);
    n = 0;
    while (pme === 1'b1 && n < PLS + 10) begin
      @(posedge clk);
      n++;
    end
    chk(n, PLS);
    bus(0, 8'h00, 4'hF, 0);
    chk(rv, 32'h6016);
    wake_wait(32'h4017);
    bus(1, 8'h0C, 4'h1, 32'h0);
    bus(1, 8'h00, 4'h1, 32'h16);
    carrier <= 1'b0;
    bus(0, 8'h00, 4'hF, 0);
    chk(rv[5:4], 0);
    $display("test deep sleep done");
    bus(1, 8'h0C, 4'h1, 32'h1);
    repeat (2) @(posedge clk);
    chk(pwr_n, 0);
    bus(1, 8'h0C, 4'h1, 32'h0);
    seen = 1'b0;
    repeat (6) begin
      seen = seen | prst;
      @(posedge clk);
    end
    chk({seen, pwr_n}, 2'b11);
    $display("test phy power-down done");
    tally_and_finish;
  end
endmodule // tb
